// File: core/timer16_flags_defines.svh
// constants for the 16-bit timer interrupt flag block: offsets, bit positions, resets, mode codes
// assumes inclusion by bare name from the package and the design modules
`ifndef TIMER16_FLAGS_DEFINES_SVH
`define TIMER16_FLAGS_DEFINES_SVH

// apb byte offsets, one aligned word per register
`define OFS_TC1_FLAGS    12'h000
`define OFS_TC3_FLAGS    12'h004
`define OFS_TC1_MASK     12'h008
`define OFS_TC3_MASK     12'h00c
`define OFS_TC1_CAPTURE  12'h010
`define OFS_TC3_CAPTURE  12'h014

// bit positions shared by the flag and mask layouts
`define BIT_OVERFLOW     0
`define BIT_CMP_A        1
`define BIT_CMP_B        2
`define BIT_CMP_C        3
`define BIT_CAPTURE      5

// implemented bits; 7, 6 and 4 stay zero
`define FLAG_IMPL_MASK   8'h2f
`define FLAG_RESET       8'h00
`define MASK_RESET       8'h00
`define CAPTURE_RESET    16'h0000

// waveform mode codes the flag logic cares about
`define MODE_NORMAL      4'h0
`define MODE_CTC_CMP_A   4'h4
`define MODE_PC_CAPT     4'h8
`define MODE_PFC_CAPT    4'ha
`define MODE_CTC_CAPT    4'hc
`define MODE_FAST_CAPT   4'he

`endif

// File: core/timer16_flags_pkg.sv
// types and mode decode helpers for the 16-bit timer interrupt flag block
// assumes the defines header is on the include path
`default_nettype none
`include "timer16_flags_defines.svh"

package timer16_flags_pkg;

  typedef logic [7:0]  flag_vec_t;   // flag or mask byte
  typedef logic [15:0] count_t;      // counter width
  typedef logic [3:0]  waveform_mode_t;

  // apb slave progress
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,                 // waiting for a setup cycle
    ST_RESP = 2'b01                  // answer stands, pready high
  } apb_state_e;

  // capture register serves as the counting top in these modes
  function automatic logic mode_capture_top(input waveform_mode_t m);
    mode_capture_top = (m == `MODE_PC_CAPT) || (m == `MODE_PFC_CAPT) ||
                       (m == `MODE_CTC_CAPT) || (m == `MODE_FAST_CAPT);
  endfunction : mode_capture_top

  // overflow taken from the plain wrap in these modes
  function automatic logic mode_wrap_overflow(input waveform_mode_t m);
    mode_wrap_overflow = (m == `MODE_NORMAL) || (m == `MODE_CTC_CMP_A);
  endfunction : mode_wrap_overflow

endpackage : timer16_flags_pkg
`default_nettype wire

// File: core/timer16_event_detect.sv
// event detection for one 16-bit timer: compare matches, capture, overflow
// assumes all inputs synchronous to i_ref_clk and i_tick a one-cycle timer clock enable
`default_nettype none
`include "timer16_flags_defines.svh"

module timer16_event_detect
  import timer16_flags_pkg::*;
(
  input  wire logic           i_ref_clk,
  input  wire logic           i_rst,
  input  wire logic           i_tick,          // timer clock enable
  input  wire count_t         i_counter_value,
  input  wire count_t         i_cmp_a,
  input  wire count_t         i_cmp_b,
  input  wire count_t         i_cmp_c,
  input  wire logic           i_capture_pin,
  input  wire waveform_mode_t i_mode,
  input  wire logic           i_counter_write, // counter written by software
  input  wire logic           i_wrap,          // counter passed max this tick
  input  wire logic           i_alt_overflow,  // overflow point of pwm modes
  output var  flag_vec_t      o_set,           // one-cycle set pulses
  output var  count_t         o_capture_value
);

  logic   pin_prev_r;   // last pin level, for edge detection
  logic   block_r;      // counter write blocks the next timer cycle's compare matches
  count_t capture_r;    // captured counter value
  logic   edge_seen;
  logic   cap_top;
  logic   match_ok;

  assign cap_top  = mode_capture_top(i_mode);
  // a write now or one pending blocks the following compare
  assign match_ok = i_tick && !block_r && !i_counter_write;
  assign edge_seen = i_capture_pin && !pin_prev_r;

  // set pulses land on the tick edge, except a pin-edge capture, so flags show in the next timer cycle
  // force strobes never reach this path, only true equality sets a compare flag
  always_comb begin
    o_set = `FLAG_RESET;
    o_set[`BIT_CMP_A] = match_ok && (i_counter_value == i_cmp_a);
    o_set[`BIT_CMP_B] = match_ok && (i_counter_value == i_cmp_b);
    o_set[`BIT_CMP_C] = match_ok && (i_counter_value == i_cmp_c);
    if (cap_top) begin
      o_set[`BIT_CAPTURE] = i_tick && (i_counter_value == capture_r);
    end else begin
      o_set[`BIT_CAPTURE] = edge_seen;
    end
    if (mode_wrap_overflow(i_mode)) begin
      o_set[`BIT_OVERFLOW] = i_tick && i_wrap;
    end else begin
      o_set[`BIT_OVERFLOW] = i_tick && i_alt_overflow;
    end
  end

  // pin history, block window and capture load
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pin_prev_r <= 1'b0;
      block_r    <= 1'b0;
      capture_r  <= `CAPTURE_RESET;
    end else begin
      pin_prev_r <= i_capture_pin;
      if (i_counter_write) begin
        block_r <= 1'b1;
      end else if (i_tick) begin
        block_r <= 1'b0;
      end
      // capture register is the top in those modes, so the pin leaves it alone
      if (edge_seen && !cap_top) begin
        capture_r <= i_counter_value;
      end
    end
  end

  assign o_capture_value = capture_r;

endmodule : timer16_event_detect
`default_nettype wire

// File: core/timer16_flag_reg.sv
// one timer's flag byte: hardware set, acknowledge clear, write-one clear
// assumes set, ack and clear vectors use the flag bit layout
`default_nettype none
`include "timer16_flags_defines.svh"

module timer16_flag_reg
  import timer16_flags_pkg::*;
(
  input  wire logic      i_ref_clk,
  input  wire logic      i_rst,
  input  wire flag_vec_t i_set,    // hardware events
  input  wire flag_vec_t i_ack,    // vector executed
  input  wire flag_vec_t i_w1c,    // software write data, qualified
  output var  flag_vec_t o_flags
);

  flag_vec_t flags_r;
  flag_vec_t flags_nxt;

  // a set in the clearing cycle wins; zeros written leave bits alone
  assign flags_nxt = ((flags_r & ~(i_ack | i_w1c)) | i_set) & `FLAG_IMPL_MASK;

  // flag storage
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      flags_r <= `FLAG_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign o_flags = flags_r;

endmodule : timer16_flag_reg
`default_nettype wire

// File: core/timer16_interrupt_flags.sv
// interrupt flags, masks and requests for the two 16-bit timers, registers over apb
// assumes timer counters, compare registers and mode live outside and arrive synchronous
//
// Design decisions made here: the APB register port and the placing of the registers.
`default_nettype none
`include "timer16_flags_defines.svh"

module timer16_interrupt_flags
  import timer16_flags_pkg::*;
(
  input  wire logic           i_ref_clk,
  input  wire logic           i_rst,
  // apb slave
  input  wire logic           i_psel,
  input  wire logic           i_penable,
  input  wire logic           i_pwrite,
  input  wire logic [11:0]    i_paddr,
  input  wire logic [31:0]    i_pwdata,
  output var  logic [31:0]    o_prdata,
  output var  logic           o_pready,
  output var  logic           o_pslverr,
  // core side
  input  wire logic           i_global_int_en,
  // timer 1
  input  wire logic           i_tc1_tick,
  input  wire count_t         i_tc1_counter_value,
  input  wire count_t         i_tc1_compare_a_register,
  input  wire count_t         i_tc1_compare_b_register,
  input  wire count_t         i_tc1_compare_c_register,
  input  wire logic           i_tc1_capture_input_pin,
  input  wire waveform_mode_t i_tc1_waveform_mode_field,
  input  wire logic           i_tc1_counter_write,
  input  wire logic           i_tc1_wrap,
  input  wire logic           i_tc1_alt_overflow,
  input  wire flag_vec_t      i_tc1_int_ack,
  output var  flag_vec_t      o_tc1_int_req,
  // timer 3
  input  wire logic           i_tc3_tick,
  input  wire count_t         i_tc3_counter_value,
  input  wire count_t         i_tc3_compare_a_register,
  input  wire count_t         i_tc3_compare_b_register,
  input  wire count_t         i_tc3_compare_c_register,
  input  wire logic           i_tc3_capture_input_pin,
  input  wire waveform_mode_t i_tc3_waveform_mode_field,
  input  wire logic           i_tc3_counter_write,
  input  wire logic           i_tc3_wrap,
  input  wire logic           i_tc3_alt_overflow,
  input  wire flag_vec_t      i_tc3_int_ack,
  output var  flag_vec_t      o_tc3_int_req
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  apb_state_e  state_r;         // apb progress
  apb_state_e  state_nxt;
  logic [31:0] prdata_r;        // read answer
  logic [31:0] prdata_nxt;
  logic        pslverr_r;       // unmapped address answer
  logic        pslverr_nxt;
  flag_vec_t   tc1_mask_r;      // timer 1 enables
  flag_vec_t   tc3_mask_r;      // timer 3 enables
  flag_vec_t   tc1_req_r;       // timer 1 requests
  flag_vec_t   tc3_req_r;       // timer 3 requests
  flag_vec_t   tc1_req_nxt;
  flag_vec_t   tc3_req_nxt;

  flag_vec_t   tc1_set;         // timer 1 event pulses
  flag_vec_t   tc3_set;         // timer 3 event pulses
  flag_vec_t   tc1_flags;       // timer 1 flag byte
  flag_vec_t   tc3_flags;       // timer 3 flag byte
  count_t      tc1_capture;     // timer 1 captured value
  count_t      tc3_capture;     // timer 3 captured value
  flag_vec_t   tc1_w1c;         // timer 1 write-one clear
  flag_vec_t   tc3_w1c;         // timer 3 write-one clear

  logic        setup_seen;      // access phase, answer not yet given
  logic        commit;          // the edge where the transfer completes
  logic        wr_commit;       // write takes effect at this edge
  logic        hit_tc1_flags;
  logic        hit_tc3_flags;
  logic        hit_tc1_mask;
  logic        hit_tc3_mask;
  logic        hit_tc1_capt;
  logic        hit_tc3_capt;
  logic        addr_mapped;
  logic [31:0] rd_mux;          // read value before registering

  ////////////////////////////////////////////////////////////////////////////////
  // event detection, one instance per timer

  timer16_event_detect u_tc1_events (
    .i_ref_clk       (i_ref_clk),
    .i_rst           (i_rst),
    .i_tick          (i_tc1_tick),
    .i_counter_value (i_tc1_counter_value),
    .i_cmp_a         (i_tc1_compare_a_register),
    .i_cmp_b         (i_tc1_compare_b_register),
    .i_cmp_c         (i_tc1_compare_c_register),
    .i_capture_pin   (i_tc1_capture_input_pin),
    .i_mode          (i_tc1_waveform_mode_field),
    .i_counter_write (i_tc1_counter_write),
    .i_wrap          (i_tc1_wrap),
    .i_alt_overflow  (i_tc1_alt_overflow),
    .o_set           (tc1_set),
    .o_capture_value (tc1_capture)
  );

  timer16_event_detect u_tc3_events (
    .i_ref_clk       (i_ref_clk),
    .i_rst           (i_rst),
    .i_tick          (i_tc3_tick),
    .i_counter_value (i_tc3_counter_value),
    .i_cmp_a         (i_tc3_compare_a_register),
    .i_cmp_b         (i_tc3_compare_b_register),
    .i_cmp_c         (i_tc3_compare_c_register),
    .i_capture_pin   (i_tc3_capture_input_pin),
    .i_mode          (i_tc3_waveform_mode_field),
    .i_counter_write (i_tc3_counter_write),
    .i_wrap          (i_tc3_wrap),
    .i_alt_overflow  (i_tc3_alt_overflow),
    .o_set           (tc3_set),
    .o_capture_value (tc3_capture)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // flag bytes, cleared by acknowledge or a written one

  // the core pulses ack when it runs a vector; we only clear on it
  timer16_flag_reg u_tc1_flags (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_set     (tc1_set),
    .i_ack     (i_tc1_int_ack),
    .i_w1c     (tc1_w1c),
    .o_flags   (tc1_flags)
  );

  timer16_flag_reg u_tc3_flags (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_set     (tc3_set),
    .i_ack     (i_tc3_int_ack),
    .i_w1c     (tc3_w1c),
    .o_flags   (tc3_flags)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // apb address decode

  // one wait state: setup, then access with pready low, then pready high
  assign setup_seen    = i_psel && i_penable && (state_r == ST_IDLE);
  assign commit        = i_psel && i_penable && (state_r == ST_RESP);
  assign wr_commit     = commit && i_pwrite;

  assign hit_tc1_flags = (i_paddr == `OFS_TC1_FLAGS);
  assign hit_tc3_flags = (i_paddr == `OFS_TC3_FLAGS);
  assign hit_tc1_mask  = (i_paddr == `OFS_TC1_MASK);
  assign hit_tc3_mask  = (i_paddr == `OFS_TC3_MASK);
  assign hit_tc1_capt  = (i_paddr == `OFS_TC1_CAPTURE);
  assign hit_tc3_capt  = (i_paddr == `OFS_TC3_CAPTURE);
  assign addr_mapped   = hit_tc1_flags || hit_tc3_flags || hit_tc1_mask ||
                         hit_tc3_mask || hit_tc1_capt || hit_tc3_capt;

  // write-one clear; the zeros in the word leave flags as they are
  assign tc1_w1c = (wr_commit && hit_tc1_flags) ? i_pwdata[7:0] : `FLAG_RESET;
  assign tc3_w1c = (wr_commit && hit_tc3_flags) ? i_pwdata[7:0] : `FLAG_RESET;

  // read mux; unused upper bits and reserved bits read zero
  assign rd_mux = hit_tc1_flags ? {24'h000000, tc1_flags}  :
                  hit_tc3_flags ? {24'h000000, tc3_flags}  :
                  hit_tc1_mask  ? {24'h000000, tc1_mask_r} :
                  hit_tc3_mask  ? {24'h000000, tc3_mask_r} :
                  hit_tc1_capt  ? {16'h0000, tc1_capture}  :
                  hit_tc3_capt  ? {16'h0000, tc3_capture}  :
                  32'h00000000;

  ////////////////////////////////////////////////////////////////////////////////
  // apb answer state machine

  // the answer is captured while pready is still low, so the read value
  // is the one seen one cycle before completion; a flag set at the edge
  // where pready rises is therefore visible only to the next read
  always_comb begin
    state_nxt   = state_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    case (state_r)
      ST_IDLE: begin
        if (setup_seen) begin
          state_nxt   = ST_RESP;
          prdata_nxt  = i_pwrite ? 32'h00000000 : rd_mux;
          pslverr_nxt = !addr_mapped;
        end
      end
      ST_RESP: begin
        // transfer ends here; drop the answer for the next one
        state_nxt   = ST_IDLE;
        prdata_nxt  = 32'h00000000;
        pslverr_nxt = 1'b0;
      end
      default: begin
        state_nxt   = ST_IDLE;
        prdata_nxt  = 32'h00000000;
        pslverr_nxt = 1'b0;
      end
    endcase
  end

  // apb registers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_r   <= ST_IDLE;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign o_pready  = (state_r == ST_RESP);
  assign o_prdata  = prdata_r;
  assign o_pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////////////
  // mask registers

  // only implemented enable bits are kept; the rest read zero
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      tc1_mask_r <= `MASK_RESET;
      tc3_mask_r <= `MASK_RESET;
    end else begin
      if (wr_commit && hit_tc1_mask) begin
        tc1_mask_r <= i_pwdata[7:0] & `FLAG_IMPL_MASK;
      end
      if (wr_commit && hit_tc3_mask) begin
        tc3_mask_r <= i_pwdata[7:0] & `FLAG_IMPL_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt requests

  // request per source: flag and enable and global flag, registered so the
  // output comes from a flop; this costs one cycle after the flag sets
  assign tc1_req_nxt = i_global_int_en ? (tc1_flags & tc1_mask_r) : `FLAG_RESET;
  assign tc3_req_nxt = i_global_int_en ? (tc3_flags & tc3_mask_r) : `FLAG_RESET;

  // request flops
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      tc1_req_r <= `FLAG_RESET;
      tc3_req_r <= `FLAG_RESET;
    end else begin
      tc1_req_r <= tc1_req_nxt;
      tc3_req_r <= tc3_req_nxt;
    end
  end

  assign o_tc1_int_req = tc1_req_r;
  assign o_tc3_int_req = tc3_req_r;

endmodule : timer16_interrupt_flags
`default_nettype wire

// File: verification/timer16_flags_assertions.sv
// checker for the timer flag block, bound to the top module ports
// assumes one clock domain with a synchronous active high reset
`default_nettype none
module timer16_flags_assertions
  import timer16_flags_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_global_int_en,
  input wire logic        i_tc1_tick,
  input wire logic        i_tc1_capture_input_pin,
  input wire flag_vec_t   i_tc1_int_ack,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire flag_vec_t   o_tc1_int_req,
  input wire flag_vec_t   o_tc3_int_req
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////
  // access phase still waiting for its answer
  sequence access_s;
    i_psel && i_penable && !o_pready;
  endsequence
  // answer stands exactly one cycle
  sequence answer_s;
    o_pready ##1 !o_pready;
  endsequence
  // request gone two cycles after the acknowledge
  sequence cleared_s(bit_idx);
    ##2 !o_tc1_int_req[bit_idx];
  endsequence
  ////////////////////////////////////////
  apb_wait_a: assert property (access_s |=> answer_s)
    else $error("apb answer not one cycle after access");
  err_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("slave error outside answer cycle");
  rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data not zero outside answer");
  req_rsvd_a: assert property ({o_tc1_int_req[7:6], o_tc1_int_req[4], o_tc3_int_req[7:6], o_tc3_int_req[4]} == 6'h0)
    else $error("reserved request bit set");
  req_global_a: assert property (!i_global_int_en |=> o_tc1_int_req == 8'h00 && o_tc3_int_req == 8'h00)
    else $error("request while global flag clear");
  req_rise_a: assert property ($rose(o_tc1_int_req[1]) |-> $past(i_global_int_en))
    else $error("compare a request rose without global flag");
  // a set in the same cycle would win, so ticks are left out
  ack_cmp_a: assert property (i_tc1_int_ack[1] && !i_tc1_tick |-> cleared_s(1))
    else $error("compare a request held after ack");
  ack_ovf_a: assert property (i_tc1_int_ack[0] && !i_tc1_tick |-> cleared_s(0))
    else $error("overflow request held after ack");
  ack_cap_a: assert property (i_tc1_int_ack[5] && !i_tc1_tick && !$rose(i_tc1_capture_input_pin)
    |-> cleared_s(5))
    else $error("capture request held after ack");
endmodule : timer16_flags_assertions

bind timer16_interrupt_flags timer16_flags_assertions u_chk (.*);
`default_nettype wire

// File: verification/timer16_core_model.sv
// model of the core interrupt logic: answers one request at a time
// assumes requests are levels that drop two cycles after the ack
`default_nettype none
module timer16_core_model
  import timer16_flags_pkg::*;
(
  input  wire logic      i_ref_clk,
  input  wire logic      i_rst,
  input  wire flag_vec_t i_int_req,
  output var  flag_vec_t o_int_ack
);
  logic [1:0] hold_r;  // cycles left before the next vector
  ////////////////////////////////////////
  // run the lowest pending vector, then wait for the request to drop
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_int_ack <= 8'h00;
      hold_r    <= 2'h0;
    end else begin
      o_int_ack <= 8'h00;
      if (hold_r != 2'h0) begin
        hold_r <= hold_r - 2'h1;
      end else if (i_int_req != 8'h00) begin
        o_int_ack <= i_int_req & (~i_int_req + 8'h01);
        hold_r    <= 2'h3;
      end
    end
  end
endmodule : timer16_core_model
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench for the timer flag block, registers over apb
// assumes both timers share stimulus except counter writes; core models answer requests
`default_nettype none
`include "timer16_flags_defines.svh"
module testbench
  import timer16_flags_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic           clk;           // reference clock
  logic           rst;           // synchronous reset
  logic           psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata, rdat;
  logic           gie, tick, pin, wrap, alt;
  logic           cw;            // timer 1 counter written by software
  count_t         cnt, ca, cb, cc;
  waveform_mode_t mode;
  flag_vec_t      ack1, ack3, req1, req3, seen_req;
  int             fail_count, total_checks;
  ////////////////////////////////////////
  // timer 1 sees counter writes, timer 3 never does, so the two can differ
  timer16_interrupt_flags u_dut (
    .i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_global_int_en(gie),
    .i_tc1_tick(tick), .i_tc1_counter_value(cnt), .i_tc1_compare_a_register(ca),
    .i_tc1_compare_b_register(cb), .i_tc1_compare_c_register(cc), .i_tc1_capture_input_pin(pin),
    .i_tc1_waveform_mode_field(mode), .i_tc1_counter_write(cw), .i_tc1_wrap(wrap),
    .i_tc1_alt_overflow(alt), .i_tc1_int_ack(ack1), .o_tc1_int_req(req1),
    .i_tc3_tick(tick), .i_tc3_counter_value(cnt), .i_tc3_compare_a_register(ca),
    .i_tc3_compare_b_register(cb), .i_tc3_compare_c_register(cc), .i_tc3_capture_input_pin(pin),
    .i_tc3_waveform_mode_field(mode), .i_tc3_counter_write(1'b0), .i_tc3_wrap(wrap),
    .i_tc3_alt_overflow(alt), .i_tc3_int_ack(ack3), .o_tc3_int_req(req3));
  timer16_core_model u_core1 (.i_ref_clk(clk), .i_rst(rst), .i_int_req(req1), .o_int_ack(ack1));
  timer16_core_model u_core3 (.i_ref_clk(clk), .i_rst(rst), .i_int_req(req3), .o_int_ack(ack3));
  ////////////////////////////////////////
  // clock and a record of every timer 1 request source seen
  always #2.5 clk = ~clk;
  always @(posedge clk) seen_req <= rst ? 8'h00 : (seen_req | req1);
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      $display("MISMATCH t=%0t no pready", $time);
    end
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic xerr);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
    chk({31'h0, rerr}, {31'h0, xerr});
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  // one timer tick with the counter at v
  task automatic hit(input count_t v);
    @(posedge clk);
    cnt  <= v;
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
  endtask : hit
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////
  // watchdog: the tests need well under two thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    $display("MISMATCH t=%0t watchdog", $time);
    stop_test();
  end
  ////////////////////////////////////////
  // main sequence
  initial begin
    {clk, psel, penable, pwrite, gie, tick, pin, wrap, alt, cw} = '0;
    rst = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    cnt = 16'h0000;
    ca = 16'h000a;
    cb = 16'h0014;
    cc = 16'h001e;
    mode = `MODE_NORMAL;
    fail_count = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(`OFS_TC1_FLAGS, 32'h0, 1'b0);
    rd(`OFS_TC3_FLAGS, 32'h0, 1'b0);
    rd(`OFS_TC1_MASK, 32'h0, 1'b0);
    rd(`OFS_TC1_CAPTURE, 32'h0, 1'b0);
    rd(12'h020, 32'h0, 1'b1);
    hit(16'h000a);
    rd(`OFS_TC1_FLAGS, 32'h02, 1'b0);
    hit(16'h0014);
    rd(`OFS_TC1_FLAGS, 32'h06, 1'b0);
    hit(16'h001e);
    rd(`OFS_TC1_FLAGS, 32'h0e, 1'b0);
    wrap <= 1'b1;
    hit(16'h0005);
    rd(`OFS_TC1_FLAGS, 32'h0f, 1'b0);
    wr(`OFS_TC1_FLAGS, 32'h01);
    rd(`OFS_TC1_FLAGS, 32'h0e, 1'b0);
    mode <= `MODE_PC_CAPT;
    hit(16'h0005);
    rd(`OFS_TC1_FLAGS, 32'h0e, 1'b0);
    wrap <= 1'b0;
    alt  <= 1'b1;
    hit(16'h0005);
    alt  <= 1'b0;
    rd(`OFS_TC1_FLAGS, 32'h0f, 1'b0);
    mode <= `MODE_NORMAL;
    @(posedge clk);
    cnt <= 16'h1234;
    pin <= 1'b1;
    rd(`OFS_TC1_FLAGS, 32'h2f, 1'b0);
    rd(`OFS_TC3_CAPTURE, 32'h1234, 1'b0);
    pin <= 1'b0;
    wr(`OFS_TC1_CAPTURE, 32'h0);
    rd(`OFS_TC1_CAPTURE, 32'h1234, 1'b0);
    wr(`OFS_TC1_FLAGS, 32'h0);
    rd(`OFS_TC1_FLAGS, 32'h2f, 1'b0);
    wr(`OFS_TC1_FLAGS, 32'hff);
    rd(`OFS_TC1_FLAGS, 32'h00, 1'b0);
    // a counter write blocks the match on the following tick
    cw <= 1'b1;
    @(posedge clk);
    cw <= 1'b0;
    hit(16'h000a);
    rd(`OFS_TC1_FLAGS, 32'h00, 1'b0);
    wr(`OFS_TC3_MASK, 32'hff);
    rd(`OFS_TC3_MASK, 32'h2f, 1'b0);
    mode <= `MODE_CTC_CAPT;
    hit(16'h1234);
    rd(`OFS_TC1_FLAGS, 32'h20, 1'b0);
    mode <= `MODE_NORMAL;
    wr(`OFS_TC1_FLAGS, 32'h20);
    gie <= 1'b1;
    hit(16'h000a);
    repeat (6) @(posedge clk);
    chk({24'h0, req1}, 32'h0);
    rd(`OFS_TC1_FLAGS, 32'h02, 1'b0);
    wr(`OFS_TC1_FLAGS, 32'h02);
    gie <= 1'b0;
    wr(`OFS_TC1_MASK, 32'h2f);
    hit(16'h0014);
    repeat (6) @(posedge clk);
    chk({24'h0, req1}, 32'h0);
    rd(`OFS_TC1_FLAGS, 32'h04, 1'b0);
    gie <= 1'b1;
    repeat (10) @(posedge clk);
    rd(`OFS_TC1_FLAGS, 32'h00, 1'b0);
    hit(16'h000a);
    hit(16'h001e);
    wrap <= 1'b1;
    hit(16'h0005);
    wrap <= 1'b0;
    @(posedge clk);
    pin <= 1'b1;
    repeat (30) @(posedge clk);
    pin <= 1'b0;
    rd(`OFS_TC1_FLAGS, 32'h00, 1'b0);
    chk({24'h0, seen_req}, 32'h2f);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
